/* File: include/sse_pkg.sv */
// Constants and types for the skip and subtract execution block
package sse_pkg;
    localparam int DW = 8;
    localparam int BW = 3;

    // Operation selects presented by the sequencer
    typedef enum logic [2:0] {
        SSE_OP_NONE     = 3'h0,
        SSE_OP_INC_SKIP = 3'h1,
        SSE_OP_INC_WREG = 3'h2,
        SSE_OP_BIT_SKIP = 3'h3,
        SSE_OP_NZ_SKIP  = 3'h4,
        SSE_OP_SUB_WREG = 3'h5,
        SSE_OP_SUB_MEM  = 3'h6
    } sse_op_e;

    // Execution states, Gray coded along exec -> dummy -> exec
    typedef enum logic [1:0] {
        SSE_ST_EXEC  = 2'h0,
        SSE_ST_DUMMY = 2'h1
    } sse_state_e;

    localparam logic [DW-1:0] SSE_ZERO_BYTE = 8'h00;
    localparam logic [DW-1:0] SSE_ONE_BYTE  = 8'h01;
    localparam logic [DW-1:0] SSE_WREG_RST  = 8'h00;
    localparam int            SSE_MSB       = DW - 1;
    localparam int            SSE_NIB_MSB   = 3;
endpackage : sse_pkg

/* File: hw/sse_sub8.sv */
// Eight-bit subtractor producing the arithmetic status flags
`timescale 1ns/100ps
module sse_sub8
    import sse_pkg::*;
(
    // Operands
    input  wire logic [sse_pkg::DW-1:0] minuend_i,
    input  wire logic [sse_pkg::DW-1:0] subtrahend_i,
    input  wire logic                   zero_prev_i,
    // Result and flags
    output logic      [sse_pkg::DW-1:0] diff_o,
    output logic                        carry_o,
    output logic                        half_carry_o,
    output logic                        overflow_o,
    output logic                        zero_o,
    output logic                        signed_cmp_o,
    output logic                        chain_zero_o
);
    import sse_pkg::*;

    // Byte and low nibble differences, each with its borrow bit on top
    logic [sse_pkg::DW:0]  wide;
    logic [SSE_NIB_MSB+1:0] low;

    always_comb begin
        wide = {1'b0, minuend_i} - {1'b0, subtrahend_i};
        low  = {1'b0, minuend_i[SSE_NIB_MSB:0]}
             - {1'b0, subtrahend_i[SSE_NIB_MSB:0]};
        diff_o       = wide[DW-1:0];
        // Carry means no borrow
        carry_o      = ~wide[DW];
        half_carry_o = ~low[SSE_NIB_MSB+1];
        overflow_o   = (minuend_i[SSE_MSB] ^ subtrahend_i[SSE_MSB])
                     & (minuend_i[SSE_MSB] ^ wide[SSE_MSB]);
        zero_o       = (wide[DW-1:0] == SSE_ZERO_BYTE);
        signed_cmp_o = wide[SSE_MSB] ^ overflow_o;
        // Chained zero keeps earlier zero across multi-byte compares
        chain_zero_o = zero_o & zero_prev_i;
    end
endmodule : sse_sub8

/* File: hw/sse_exec.sv */
// Execution unit for increment-skip, test-skip and subtract instructions
`timescale 1ns/100ps
module sse_exec
    import sse_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   srst_i,
    // Instruction from sequencer
    input  wire logic                   op_valid_i,
    input  wire sse_pkg::sse_op_e       op_i,
    input  wire logic [sse_pkg::BW-1:0] bit_sel_i,
    input  wire logic [sse_pkg::DW-1:0] mem_rdata_i,
    // Data memory write
    output logic                        mem_we_o,
    output logic      [sse_pkg::DW-1:0] mem_wdata_o,
    // Working register and flags
    output logic      [sse_pkg::DW-1:0] working_register_o,
    output logic                        carry_flag_o,
    output logic                        half_carry_flag_o,
    output logic                        overflow_flag_o,
    output logic                        zero_flag_o,
    output logic                        signed_compare_flag_o,
    output logic                        chained_zero_flag_o,
    // Sequencer handshake
    output logic                        skip_o,
    output logic                        busy_o,
    output logic                        done_o
);
    import sse_pkg::*;

    sse_state_e         state;
    sse_state_e         next_state;
    logic [DW-1:0]      inc_val;
    logic               take_skip;
    logic               is_skip_op;
    logic               is_sub_op;
    logic               accept;
    logic [DW-1:0]      sub_diff;
    logic               sub_c;
    logic               sub_ac;
    logic               sub_ov;
    logic               sub_z;
    logic               sub_sc;
    logic               sub_cz;

    sse_sub8 u_sub (
        .minuend_i    (working_register_o),
        .subtrahend_i (mem_rdata_i),
        .zero_prev_i  (zero_flag_o),
        .diff_o       (sub_diff),
        .carry_o      (sub_c),
        .half_carry_o (sub_ac),
        .overflow_o   (sub_ov),
        .zero_o       (sub_z),
        .signed_cmp_o (sub_sc),
        .chain_zero_o (sub_cz)
    );

    // Requests during the dummy cycle are not taken
    assign accept  = op_valid_i && (state == SSE_ST_EXEC);
    assign inc_val = mem_rdata_i + SSE_ONE_BYTE;

    always_comb begin
        take_skip  = 1'b0;
        is_skip_op = 1'b0;
        is_sub_op  = 1'b0;
        case (op_i)
            SSE_OP_INC_SKIP, SSE_OP_INC_WREG: begin
                is_skip_op = 1'b1;
                take_skip  = (inc_val == SSE_ZERO_BYTE);
            end
            SSE_OP_BIT_SKIP: begin
                is_skip_op = 1'b1;
                take_skip  = mem_rdata_i[bit_sel_i];
            end
            SSE_OP_NZ_SKIP: begin
                is_skip_op = 1'b1;
                take_skip  = (mem_rdata_i != SSE_ZERO_BYTE);
            end
            SSE_OP_SUB_WREG, SSE_OP_SUB_MEM: begin
                is_sub_op = 1'b1;
            end
            default: begin
                take_skip = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            SSE_ST_EXEC: begin
                // Failed condition stays in exec: one cycle
                if (accept && is_skip_op && take_skip) begin
                    next_state = SSE_ST_DUMMY;
                end
            end
            SSE_ST_DUMMY: begin
                next_state = SSE_ST_EXEC;
            end
            default: begin
                next_state = SSE_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= SSE_ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    // Memory write port
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mem_we_o    <= 1'b0;
            mem_wdata_o <= SSE_ZERO_BYTE;
        end else begin
            mem_we_o    <= 1'b0;
            if (accept) begin
                case (op_i)
                    SSE_OP_INC_SKIP: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= inc_val;
                    end
                    SSE_OP_NZ_SKIP: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= mem_rdata_i;
                    end
                    SSE_OP_SUB_MEM: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= sub_diff;
                    end
                    default: begin
                        mem_we_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Working register; the inc-to-wreg form never writes memory
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            working_register_o <= SSE_WREG_RST;
        end else if (accept) begin
            case (op_i)
                SSE_OP_INC_WREG: working_register_o <= inc_val;
                SSE_OP_SUB_WREG: working_register_o <= sub_diff;
                default: working_register_o <= working_register_o;
            endcase
        end
    end

    // Flags move only on subtracts
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            carry_flag_o          <= 1'b0;
            half_carry_flag_o     <= 1'b0;
            overflow_flag_o       <= 1'b0;
            zero_flag_o           <= 1'b0;
            signed_compare_flag_o <= 1'b0;
            chained_zero_flag_o   <= 1'b0;
        end else if (accept && is_sub_op) begin
            carry_flag_o          <= sub_c;
            half_carry_flag_o     <= sub_ac;
            overflow_flag_o       <= sub_ov;
            zero_flag_o           <= sub_z;
            signed_compare_flag_o <= sub_sc;
            chained_zero_flag_o   <= sub_cz;
        end
    end

    // Sequencer status
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            skip_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            skip_o <= accept && is_skip_op && take_skip;
            busy_o <= (next_state == SSE_ST_DUMMY);
            done_o <= accept && !(is_skip_op && take_skip)
                   || (state == SSE_ST_DUMMY);
        end
    end
endmodule : sse_exec

/* File: bench/sse_exec_chk.sv */
// Port assertions for the skip and subtract execution unit
`timescale 1ns/100ps
module sse_exec_chk
    import sse_pkg::*;
(
    // Clock, reset and request
    input wire logic                   core_clk_i,
    input wire logic                   srst_i,
    input wire logic                   op_valid_i,
    input wire sse_pkg::sse_op_e       op_i,
    input wire logic [sse_pkg::BW-1:0] bit_sel_i,
    input wire logic [sse_pkg::DW-1:0] mem_rdata_i,
    // Results
    input wire logic                   mem_we_o,
    input wire logic [sse_pkg::DW-1:0] mem_wdata_o,
    input wire logic [sse_pkg::DW-1:0] working_register_o,
    input wire logic                   carry_flag_o,
    input wire logic                   zero_flag_o,
    input wire logic                   skip_o,
    input wire logic                   busy_o,
    input wire logic                   done_o
);
    logic          tk;
    sse_op_e       o;
    logic [DW-1:0] m;
    logic [DW-1:0] w;
    logic [BW-1:0] b;
    // Operands of the request taken at the previous edge
    always_ff @(posedge core_clk_i) begin
        tk <= !srst_i && op_valid_i && !busy_o;
        o  <= op_i;
        m  <= mem_rdata_i;
        w  <= working_register_o;
        b  <= bit_sel_i;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    a_skip_dummy_cycle: assert property (skip_o |-> busy_o && !done_o
        ##1 done_o && !busy_o) else $error("skip without one dummy cycle");
    a_noskip_one_cycle: assert property (tk && o != SSE_OP_NONE
        |-> skip_o ^ done_o) else $error("answer missing after request");
    a_skip_flags_kept: assert property (tk && o inside {SSE_OP_INC_SKIP,
        SSE_OP_INC_WREG, SSE_OP_BIT_SKIP, SSE_OP_NZ_SKIP}
        |-> $stable({carry_flag_o, zero_flag_o})) else $error("flag moved");
    a_inc_mem_write: assert property (tk && o == SSE_OP_INC_SKIP
        |-> mem_we_o && mem_wdata_o == m + 8'h01
        && skip_o == (mem_wdata_o == 8'h00)) else $error("increment skip");
    a_inc_wreg_load: assert property (tk && o == SSE_OP_INC_WREG
        |-> !mem_we_o && working_register_o == m + 8'h01
        && skip_o == (working_register_o == 8'h00)) else $error("inc wreg");
    a_bit_test_skip: assert property (tk && o == SSE_OP_BIT_SKIP
        |-> skip_o == m[b] && !mem_we_o) else $error("bit test skip");
    a_nonzero_skip: assert property (tk && o == SSE_OP_NZ_SKIP
        |-> mem_we_o && mem_wdata_o == m && skip_o == (m != 8'h00))
        else $error("nonzero skip");
    a_sub_wreg_diff: assert property (tk && o == SSE_OP_SUB_WREG
        |-> !mem_we_o && working_register_o == w - m) else $error("sub wreg");
    a_sub_mem_diff: assert property (tk && o == SSE_OP_SUB_MEM
        |-> mem_we_o && mem_wdata_o == w - m && working_register_o == w)
        else $error("sub mem");
    a_sub_carry_flag: assert property (tk && o inside {SSE_OP_SUB_WREG,
        SSE_OP_SUB_MEM} |-> carry_flag_o == (w >= m)) else $error("carry");
endmodule : sse_exec_chk

bind sse_exec sse_exec_chk u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .bit_sel_i(bit_sel_i),
    .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .working_register_o(working_register_o), .carry_flag_o(carry_flag_o),
    .zero_flag_o(zero_flag_o), .skip_o(skip_o), .busy_o(busy_o),
    .done_o(done_o));

/* File: bench/sse_exec_tb.sv */
// Random and corner-case bench for the execution unit
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((e) !== (g)) begin \
    $display("wrong value %s exp %h got %h", n, e, g); num_errors++; end end
module sse_exec_tb;
    import sse_pkg::*;
    logic          clk   = 1'b0;
    logic          srst  = 1'b1;
    logic          vld   = 1'b0;
    sse_op_e       op    = SSE_OP_NONE;
    logic [BW-1:0] bsel  = 3'h0;
    logic [DW-1:0] rdata = 8'h00;
    logic          we, skip, busy, done;
    logic [DW-1:0] wd, wreg;
    logic [5:0]    flg;
    logic [DW-1:0] w_m   = 8'h00;
    logic [5:0]    f_m   = 6'h00;
    int            num_errors = 0;
    int            n_compared = 0;

    always #12.5 clk = ~clk;

    sse_exec DUT (.core_clk_i(clk), .srst_i(srst), .op_valid_i(vld),
        .op_i(op), .bit_sel_i(bsel), .mem_rdata_i(rdata), .mem_we_o(we),
        .mem_wdata_o(wd), .working_register_o(wreg), .carry_flag_o(flg[5]),
        .half_carry_flag_o(flg[4]), .overflow_flag_o(flg[3]),
        .zero_flag_o(flg[2]), .signed_compare_flag_o(flg[1]),
        .chained_zero_flag_o(flg[0]), .skip_o(skip), .busy_o(busy),
        .done_o(done));

    // Difference then carry, half carry, overflow, zero, signed, chained
    function automatic logic [13:0] exp_sub(input logic [7:0] a,
                                            input logic [7:0] s,
                                            input logic       zp);
        logic [7:0] d;
        logic       v;
        d = a - s;
        v = (a[7] != s[7]) && (d[7] != a[7]);
        return {d, a >= s, a[3:0] >= s[3:0], v, d == 8'h00, d[7] ^ v,
                (d == 8'h00) & zp};
    endfunction : exp_sub

    task automatic exec(input sse_op_e o, input logic [7:0] m,
                        input logic [2:0] b);
        logic [7:0] r;
        logic       sk;
        logic       wr;
        logic [7:0] wv;
        r = m + 8'h01;
        sk = 1'b0;
        wr = 1'b0;
        wv = m;
        case (o)
            SSE_OP_INC_SKIP: begin wr = 1'b1; wv = r; sk = (r == 8'h00); end
            SSE_OP_INC_WREG: begin w_m = r; sk = (r == 8'h00); end
            SSE_OP_BIT_SKIP: sk = m[b];
            SSE_OP_NZ_SKIP: begin wr = 1'b1; sk = (m != 8'h00); end
            default: begin
                {r, f_m} = exp_sub(w_m, m, f_m[2]);
                wr = (o == SSE_OP_SUB_MEM);
                if (wr) wv = r; else w_m = r;
            end
        endcase
        vld = 1'b1;
        op = o;
        rdata = m;
        bsel = b;
        @(posedge clk); #1;
        `CHK("mem_we", wr, we)
        if (wr) `CHK("mem_wdata", wv, wd)
        `CHK("wreg", w_m, wreg)
        `CHK("flags", f_m, flg)
        `CHK("skip", sk, skip)
        `CHK("done", !sk, done)
        `CHK("busy", sk, busy)
        if (sk) begin
            // Request during the dummy cycle must be ignored
            op = SSE_OP_INC_WREG;
            rdata = 8'($urandom);
            @(posedge clk); #1;
            `CHK("done_after_dummy", 1'b1, done)
            `CHK("wreg_in_dummy", w_m, wreg)
        end
    endtask : exec

    task automatic stop_test();
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    initial begin
        void'($urandom(80186));
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        `CHK("reset", 18'h0, {wreg, flg, we, skip, busy, done})
        exec(SSE_OP_INC_SKIP, 8'hff, 3'h0);
        exec(SSE_OP_INC_SKIP, 8'h00, 3'h0);
        exec(SSE_OP_INC_WREG, 8'hff, 3'h0);
        for (int i = 0; i < 8; i++) exec(SSE_OP_BIT_SKIP, 8'ha5, 3'(i));
        exec(SSE_OP_NZ_SKIP, 8'h00, 3'h0);
        exec(SSE_OP_NZ_SKIP, 8'h80, 3'h0);
        exec(SSE_OP_INC_WREG, 8'h0f, 3'h0);
        exec(SSE_OP_SUB_MEM, 8'h10, 3'h0);
        exec(SSE_OP_SUB_MEM, 8'h10, 3'h0);
        exec(SSE_OP_SUB_WREG, 8'h81, 3'h0);
        repeat (300) exec(sse_op_e'(3'($urandom_range(6, 1))),
                          8'($urandom), 3'($urandom));
        vld = 1'b0;
        stop_test();
    end

    // Hang guard, well beyond the longest run
    initial begin
        #75000;
        num_errors++;
        stop_test();
    end
endmodule : sse_exec_tb
